/* File: sbi_pkg.sv */
package sbi_pkg;

    // ==========================================================
    // Timing
    localparam int SBI_CLK_FREQ_HZ = 200_000_000;
    localparam int SBI_BUS_FREQ_HZ = 62_500;
    localparam int SBI_QTR_PER_BIT = 4;
    // Bus bit is split into quarters; divide rounds down so rate never falls below 62.5 kHz
    localparam int SBI_QUARTER_CYC = SBI_CLK_FREQ_HZ / (SBI_BUS_FREQ_HZ * SBI_QTR_PER_BIT);
    // Bus free time after a stop, in quarters (one bus bit)
    localparam int SBI_FREE_QTR = 4;

    // ==========================================================
    // Buffer
    localparam int SBI_BUF_DEPTH = 2;
    localparam int SBI_BYTE_W = 8;

    // ==========================================================
    // Mode select and sequencing codes
    localparam logic [1:0] SBI_MODE_OFF = 2'h0;
    localparam logic [1:0] SBI_MODE_SHIFT = 2'h1;
    localparam logic [1:0] SBI_MODE_I2C = 2'h2;
    localparam logic [1:0] SBI_MODE_SBUS = 2'h3;

    localparam logic [1:0] SBI_PH_SET = 2'h0;
    localparam logic [1:0] SBI_PH_RISE = 2'h1;
    localparam logic [1:0] SBI_PH_HIGH = 2'h2;
    localparam logic [1:0] SBI_PH_FALL = 2'h3;

    localparam logic [3:0] SBI_ACK_BIT = 4'h8;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        SBI_IDLE,
        SBI_START,
        SBI_BIT,
        SBI_STOP,
        SBI_FREE
    } sbi_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic bus_enable_line;
    } sbi_pins_s;

    typedef struct packed {
        logic sbus;
        logic start;
        logic stop;
        logic tx;
    } sbi_cfg_s;

endpackage : sbi_pkg

/* File: sbi_master.sv */
`timescale 1ns/1ps

module sbi_master
    import sbi_pkg::*;
#(
    parameter int QUARTER_CYC = SBI_QUARTER_CYC,
    parameter int FREE_QTR = SBI_FREE_QTR
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [1:0] mode,
    input wire logic start_en,
    input wire logic stop_en,
    input wire logic tx_dir,
    input wire logic go,
    input wire logic [7:0] tx_byte,
    // Status
    output logic byte_in_progress_flag,
    output logic no_ack_flag,
    // Received bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // Bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic bus_enable_line_in,
    output logic bus_enable_line_out,
    output logic bus_enable_line_oe
);

    // ==========================================================
    // Pin synchronisers
    sbi_pins_s pin_raw;
    sbi_pins_s sync1_q;
    sbi_pins_s sync2_q;

    assign pin_raw = '{scl: scl_in, sda: sda_in, bus_enable_line: bus_enable_line_in};

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Declarations
    sbi_state_e state_q;
    sbi_cfg_s cfg_q;
    sbi_pins_s drv_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [15:0] qcnt_q;
    logic [7:0] sh_q;
    logic busy_q;
    logic no_ack_q;
    logic active_q;
    logic pin_lo_q;
    logic [7:0] buf_q [SBI_BUF_DEPTH];
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic rx_valid_q;
    logic tick;
    logic adv;
    logic rd_bit;
    logic accept;
    logic byte_end;
    logic to_stop;
    logic free_end;
    logic push;
    logic pop;

    // ==========================================================
    // Bit timing
    assign tick = qcnt_q == 16'(QUARTER_CYC - 1);
    // A slave holding the clock low freezes the high phase
    assign adv = tick && !(ph_q == SBI_PH_HIGH && !sync2_q.scl);

    always_ff @(posedge clk) begin
        if (rst || state_q == SBI_IDLE || tick) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // Command and sequencing
    assign rd_bit = sync2_q.sda & (cfg_q.sbus | sync2_q.bus_enable_line);
    // Shift-register mode is not built here; it behaves as off
    assign accept = go && !busy_q && mode[1]
        && (tx_dir || cnt_q < 2'(SBI_BUF_DEPTH));
    assign byte_end = state_q == SBI_BIT && adv && ph_q == SBI_PH_FALL
        && bit_q == SBI_ACK_BIT;
    assign to_stop = cfg_q.stop || (cfg_q.tx && no_ack_q);
    assign free_end = state_q == SBI_FREE && tick && bit_q == 4'(FREE_QTR - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SBI_IDLE;
            ph_q <= SBI_PH_SET;
            bit_q <= '0;
        end else begin
            unique case (state_q)
                SBI_IDLE: begin
                    if (accept) begin
                        state_q <= start_en ? SBI_START : SBI_BIT;
                        ph_q <= SBI_PH_SET;
                        bit_q <= '0;
                    end
                end
                SBI_START: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == SBI_PH_FALL) begin
                            state_q <= SBI_BIT;
                        end
                    end
                end
                SBI_BIT: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == SBI_PH_FALL) begin
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == SBI_ACK_BIT) begin
                                bit_q <= '0;
                                state_q <= to_stop ? SBI_STOP : SBI_IDLE;
                            end
                        end
                    end
                end
                SBI_STOP: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == SBI_PH_FALL) begin
                            state_q <= SBI_FREE;
                        end
                    end
                end
                SBI_FREE: begin
                    if (tick) begin
                        bit_q <= bit_q + 4'h1;
                        if (free_end) begin
                            state_q <= SBI_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Line drive: a set bit pulls the line low, clear releases it
    always_ff @(posedge clk) begin
        if (rst || !mode[1]) begin
            drv_q <= '0;
        end else if (adv) begin
            unique case (state_q)
                SBI_START: begin
                    unique case (ph_q)
                        SBI_PH_SET: begin
                            drv_q.sda <= 1'h0;
                            drv_q.bus_enable_line <= 1'h0;
                        end
                        SBI_PH_RISE: drv_q.scl <= 1'h0;
                        SBI_PH_HIGH: begin
                            if (cfg_q.sbus) begin
                                drv_q.bus_enable_line <= 1'h1;
                            end else begin
                                drv_q.sda <= 1'h1;
                            end
                        end
                        SBI_PH_FALL: drv_q.scl <= 1'h1;
                    endcase
                end
                SBI_BIT: begin
                    unique case (ph_q)
                        SBI_PH_SET: begin
                            drv_q.bus_enable_line <= 1'h0;
                            if (bit_q == SBI_ACK_BIT) begin
                                drv_q.sda <= !cfg_q.tx && !cfg_q.stop;
                            end else begin
                                drv_q.sda <= cfg_q.tx && !sh_q[7];
                            end
                        end
                        SBI_PH_RISE: drv_q.scl <= 1'h0;
                        SBI_PH_HIGH: ;
                        SBI_PH_FALL: drv_q.scl <= 1'h1;
                    endcase
                end
                SBI_STOP: begin
                    unique case (ph_q)
                        SBI_PH_SET: begin
                            drv_q.sda <= !cfg_q.sbus;
                            drv_q.bus_enable_line <= cfg_q.sbus;
                        end
                        SBI_PH_RISE: drv_q.scl <= 1'h0;
                        SBI_PH_HIGH: begin
                            drv_q.sda <= 1'h0;
                            drv_q.bus_enable_line <= 1'h0;
                        end
                        SBI_PH_FALL: ;
                    endcase
                end
                SBI_IDLE, SBI_FREE: ;
            endcase
        end
    end

    // ==========================================================
    // Shift register doubles as transmit and receive byte
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_q <= '0;
            cfg_q <= '0;
        end else if (accept) begin
            sh_q <= tx_byte;
            cfg_q <= '{sbus: mode == SBI_MODE_SBUS, start: start_en,
                       stop: stop_en, tx: tx_dir};
        end else if (state_q == SBI_BIT && adv && ph_q == SBI_PH_HIGH
                     && bit_q != SBI_ACK_BIT) begin
            sh_q <= {sh_q[6:0], rd_bit};
        end
    end

    // ==========================================================
    // Flags
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'h0;
        end else if (accept) begin
            busy_q <= 1'h1;
        end else if ((byte_end && !to_stop) || free_end) begin
            busy_q <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || accept) begin
            no_ack_q <= 1'h0;
        end else if (state_q == SBI_BIT && adv && ph_q == SBI_PH_HIGH
                     && bit_q == SBI_ACK_BIT && cfg_q.tx && rd_bit) begin
            no_ack_q <= 1'h1;
        end
    end

    // Only this engine opens and closes a frame on the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= 1'h0;
        end else if (adv && ph_q == SBI_PH_HIGH) begin
            if (state_q == SBI_START) begin
                active_q <= 1'h1;
            end else if (state_q == SBI_STOP) begin
                active_q <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        pin_lo_q <= 1'h0;
    end

    // ==========================================================
    // Two-entry receive buffer
    assign push = byte_end && !cfg_q.tx;
    assign pop = rx_valid_q && rx_ready;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            rx_valid_q <= 1'h0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            cnt_q <= cnt_d;
            rx_valid_q <= cnt_d != 2'h0;
            if (pop) begin
                buf_q[0] <= buf_q[1];
            end
            if (push) begin
                buf_q[cnt_q[0] ^ pop] <= sh_q;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign byte_in_progress_flag = busy_q;
    assign no_ack_flag = no_ack_q;
    assign rx_valid = rx_valid_q;
    assign rx_data = buf_q[0];
    assign scl_out = pin_lo_q;
    assign sda_out = pin_lo_q;
    assign bus_enable_line_out = pin_lo_q;
    assign scl_oe = drv_q.scl;
    assign sda_oe = drv_q.sda;
    assign bus_enable_line_oe = drv_q.bus_enable_line;

    // ==========================================================
    // Checks
    property p_sbus_start;
        @(posedge clk) disable iff (rst)
        $rose(drv_q.bus_enable_line) |-> (state_q == SBI_START && !drv_q.scl)
            || (state_q == SBI_STOP && drv_q.scl);
    endproperty
    a_sbus_start: assert property (p_sbus_start)
        else $error("enable line fell outside a start");

    property p_i2c_edges;
        @(posedge clk) disable iff (rst)
        $changed(drv_q.sda) && !drv_q.scl && !$past(drv_q.scl)
            |-> !cfg_q.sbus && $past(state_q) inside {SBI_START, SBI_STOP};
    endproperty
    a_i2c_edges: assert property (p_i2c_edges)
        else $error("data moved while clock high outside start or stop");

    property p_sbus_data_low;
        @(posedge clk) disable iff (rst)
        cfg_q.sbus && busy_q && $changed(drv_q.sda) |-> drv_q.scl;
    endproperty
    a_sbus_data_low: assert property (p_sbus_data_low)
        else $error("S-BUS data changed with clock high");

    property p_sen_held;
        @(posedge clk) disable iff (rst)
        state_q == SBI_BIT && bit_q != 4'h0 |-> !drv_q.bus_enable_line;
    endproperty
    a_sen_held: assert property (p_sen_held)
        else $error("enable line not high during data");

    property p_sbus_stop;
        @(posedge clk) disable iff (rst)
        cfg_q.sbus && state_q == SBI_STOP && ph_q == SBI_PH_RISE
            |-> !drv_q.sda && drv_q.bus_enable_line;
    endproperty
    a_sbus_stop: assert property (p_sbus_stop)
        else $error("S-BUS stop setup wrong");

    property p_tx_ack_release;
        @(posedge clk) disable iff (rst)
        state_q == SBI_BIT && bit_q == SBI_ACK_BIT && cfg_q.tx && ph_q != SBI_PH_SET
            |-> !drv_q.sda;
    endproperty
    a_tx_ack_release: assert property (p_tx_ack_release)
        else $error("transmitter drove the acknowledge bit");

    property p_abort;
        @(posedge clk) disable iff (rst)
        byte_end && cfg_q.tx && no_ack_q |=> state_q == SBI_STOP;
    endproperty
    a_abort: assert property (p_abort)
        else $error("missing acknowledge did not abort");

    property p_msb_first;
        @(posedge clk) disable iff (rst)
        state_q == SBI_BIT && cfg_q.tx && bit_q < SBI_ACK_BIT && ph_q == SBI_PH_RISE
            |-> drv_q.sda == !sh_q[7];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("data bit not taken from shift MSB");

    property p_i2c_sen;
        @(posedge clk) disable iff (rst)
        busy_q && !cfg_q.sbus |-> !drv_q.bus_enable_line;
    endproperty
    a_i2c_sen: assert property (p_i2c_sen)
        else $error("enable line pulled in I2C mode");

    property p_rx_ack;
        @(posedge clk) disable iff (rst)
        state_q == SBI_BIT && bit_q == SBI_ACK_BIT && !cfg_q.tx && ph_q == SBI_PH_HIGH
            |-> drv_q.sda == !cfg_q.stop;
    endproperty
    a_rx_ack: assert property (p_rx_ack)
        else $error("receive acknowledge wrong");

    property p_free_busy;
        @(posedge clk) disable iff (rst)
        $fell(active_q) |-> busy_q [*8];
    endproperty
    a_free_busy: assert property (p_free_busy)
        else $error("busy dropped right after stop");

    property p_noack_clear;
        @(posedge clk) disable iff (rst)
        $rose(busy_q) |-> !no_ack_q ##1 state_q != SBI_IDLE;
    endproperty
    a_noack_clear: assert property (p_noack_clear)
        else $error("no-ack not cleared on new byte");

endmodule : sbi_master

/* File: sbi_slave_model.sv */
`timescale 1ns/1ps

module sbi_slave_model #(
    parameter int STRETCH_NS = 400
) (
    // Bus lines, released high by pull-ups
    input wire logic scl,
    input wire logic sda,
    input wire logic bus_enable_line,
    output logic scl_pull,
    output logic sda_pull,
    // Scenario control
    input wire logic sbus,
    input wire logic ack_en,
    input wire logic stretch,
    input wire logic [7:0] rd_byte,
    // Observation
    output logic [7:0] last_byte,
    output logic master_ack,
    output logic [7:0] n_start,
    output logic [7:0] n_stop
);
    // ==========================================================
    // Line decoding
    logic [7:0] sr = 8'h00;
    int bit_n = 0;
    logic first = 1'b0;
    logic slave_tx = 1'b0;
    wire logic dat = sbus ? sda : (sda & bus_enable_line);
    // Start and stop ride on the enable line in S-BUS, on data in I2C
    wire logic frame = sbus ? bus_enable_line : dat;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        last_byte = 8'h00;
        master_ack = 1'b1;
        n_start = 8'h00;
        n_stop = 8'h00;
    end

    always @(negedge frame) begin
        if (scl) begin
            n_start = n_start + 8'h01;
            bit_n = 0;
            first = 1'b1;
            slave_tx = 1'b0;
        end
    end

    always @(posedge frame) begin
        if (scl) begin
            n_stop = n_stop + 8'h01;
        end
    end

    // ==========================================================
    // Bit handling
    always @(posedge scl) begin
        if (bit_n < 8) begin
            sr = {sr[6:0], dat};
            if (bit_n == 7) begin
                last_byte = sr;
            end
            bit_n++;
        end else begin
            if (slave_tx) begin
                master_ack = dat;
                // A refused byte ends our turn so the master can make its stop
                slave_tx = !dat;
            end else if (first) begin
                slave_tx = last_byte[0];
            end
            first = 1'b0;
            bit_n = 0;
        end
    end

    // Data moves only while the clock is low
    always @(negedge scl) begin
        sda_pull <= (bit_n == 8 && !slave_tx && ack_en)
            || (bit_n < 8 && slave_tx && !rd_byte[7 - bit_n]);
        if (stretch) begin
            scl_pull <= 1'b1;
            scl_pull <= #(STRETCH_NS) 1'b0;
        end
    end
endmodule : sbi_slave_model

/* File: testbench.sv */
`timescale 1ns/1ps

module testbench
    import sbi_pkg::*;
;
    // ==========================================================
    // Stimulus and wiring
    localparam int QC = 8;
    localparam int FQ = 2;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = SBI_MODE_I2C;
    logic start_en = 1'b0;
    logic stop_en = 1'b0;
    logic tx_dir = 1'b0;
    logic go = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic rx_ready = 1'b0;
    logic busy, no_ack, rx_valid, scl_oe, sda_oe, sen_oe, scl_pull, sda_pull;
    logic [7:0] rx_data, last_byte, n_start, n_stop, stop_d, s0, p0;
    logic master_ack, took, scl_d;
    logic scl_o, sda_o, sen_o;
    logic ack_en = 1'b1;
    logic stretch = 1'b0;
    logic sen_bad = 1'b0;
    logic [7:0] rd_byte = 8'h00;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int last_rise = 0;
    int period = 0;
    int stop_cyc = 0;
    sbi_pins_s bus_w;

    assign bus_w = '{scl: ~(scl_oe | scl_pull), sda: ~(sda_oe | sda_pull), bus_enable_line: ~sen_oe};

    always #2.5 clk = ~clk;

    sbi_master #(.QUARTER_CYC(QC), .FREE_QTR(FQ)) u_sbi_master (
        .clk(clk), .rst(rst), .mode(mode), .start_en(start_en), .stop_en(stop_en),
        .tx_dir(tx_dir), .go(go), .tx_byte(tx_byte), .byte_in_progress_flag(busy),
        .no_ack_flag(no_ack), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .scl_in(bus_w.scl), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(bus_w.sda),
        .sda_out(sda_o), .sda_oe(sda_oe), .bus_enable_line_in(bus_w.bus_enable_line),
        .bus_enable_line_out(sen_o),
        .bus_enable_line_oe(sen_oe)
    );

    sbi_slave_model u_sbi_slave_model (
        .scl(bus_w.scl), .sda(bus_w.sda), .bus_enable_line(bus_w.bus_enable_line), .scl_pull(scl_pull),
        .sda_pull(sda_pull), .sbus(mode == SBI_MODE_SBUS), .ack_en(ack_en),
        .stretch(stretch), .rd_byte(rd_byte), .last_byte(last_byte),
        .master_ack(master_ack), .n_start(n_start), .n_stop(n_stop)
    );

    // Bus clock period, stop moment and enable line use in I2C
    always @(posedge clk) begin
        cyc <= cyc + 1;
        scl_d <= bus_w.scl;
        stop_d <= n_stop;
        if (bus_w.scl && !scl_d) begin
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (n_stop != stop_d) stop_cyc <= cyc;
        if (mode == SBI_MODE_I2C && sen_oe) sen_bad <= 1'b1;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic op(input logic s, input logic p, input logic t, input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk);
        start_en <= s;
        stop_en <= p;
        tx_dir <= t;
        tx_byte <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        took = busy;
        while (busy !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000) begin
            n_errors++;
            test_done();
        end
    endtask : op

    task automatic pop(input logic [7:0] exp);
        check("rx_valid", 8'(rx_valid), 8'h01);
        check("rx_data", rx_data, exp);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        @(negedge clk);
    endtask : pop

    // ==========================================================
    // Scenarios
    task automatic t_write;
        s0 = n_start;
        p0 = n_stop;
        op(1'b1, 1'b0, 1'b1, 8'hA4);
        check("taken", 8'(took), 8'h01);
        check("addr", last_byte, 8'hA4);
        check("starts", n_start, s0 + 8'h01);
        check("no_ack", 8'(no_ack), 8'h00);
        check("bit_period", 8'(period), 8'(4 * QC));
        op(1'b0, 1'b0, 1'b1, 8'h3C);
        check("data0", last_byte, 8'h3C);
        op(1'b0, 1'b1, 1'b1, 8'h96);
        check("data1", last_byte, 8'h96);
        check("stops", n_stop, p0 + 8'h01);
        check("free_time", 8'((cyc - stop_cyc) >= FQ * QC - 2), 8'h01);
        check("scl_idle", 8'(bus_w.scl), 8'h01);
    endtask : t_write

    task automatic t_read;
        rd_byte = 8'h5B;
        op(1'b1, 1'b0, 1'b1, 8'hA4);
        op(1'b0, 1'b0, 1'b1, 8'h10);
        s0 = n_start;
        op(1'b1, 1'b0, 1'b1, 8'hA5);
        check("rep_start", n_start, s0 + 8'h01);
        op(1'b0, 1'b0, 1'b0, 8'h00);
        check("mack0", 8'(master_ack), 8'h00);
        // Next byte's first bit is already on the line, so only its tail may differ
        rd_byte = 8'h2D;
        op(1'b0, 1'b0, 1'b0, 8'h00);
        rd_byte = 8'h66;
        op(1'b0, 1'b0, 1'b0, 8'h00);
        check("full_refused", 8'(took), 8'h00);
        pop(8'h5B);
        pop(8'h2D);
        check("drained", 8'(rx_valid), 8'h00);
        op(1'b0, 1'b1, 1'b0, 8'h00);
        check("mack_last", 8'(master_ack), 8'h01);
        pop(8'h66);
    endtask : t_read

    task automatic t_nack;
        ack_en = 1'b0;
        p0 = n_stop;
        op(1'b1, 1'b0, 1'b1, 8'hA4);
        check("no_ack_set", 8'(no_ack), 8'h01);
        check("abort_stop", n_stop, p0 + 8'h01);
        ack_en = 1'b1;
        op(1'b1, 1'b1, 1'b1, 8'hA4);
        check("no_ack_clr", 8'(no_ack), 8'h00);
    endtask : t_nack

    task automatic t_stretch;
        stretch = 1'b1;
        op(1'b1, 1'b0, 1'b1, 8'hA4);
        check("stretched", 8'(period > 4 * QC), 8'h01);
        check("addr_str", last_byte, 8'hA4);
        stretch = 1'b0;
        op(1'b0, 1'b1, 1'b1, 8'h5A);
        check("data_str", last_byte, 8'h5A);
    endtask : t_stretch

    task automatic t_off;
        s0 = n_start;
        @(posedge clk);
        mode <= SBI_MODE_OFF;
        op(1'b1, 1'b1, 1'b1, 8'hA4);
        check("off", 8'(took), 8'h00);
        @(posedge clk);
        mode <= SBI_MODE_SHIFT;
        op(1'b1, 1'b1, 1'b1, 8'hA4);
        check("shift", 8'(took), 8'h00);
        check("quiet", n_start, s0);
    endtask : t_off

    task automatic t_sbus;
        @(posedge clk);
        mode <= SBI_MODE_SBUS;
        s0 = n_start;
        p0 = n_stop;
        op(1'b1, 1'b0, 1'b1, 8'h72);
        check("sb_addr", last_byte, 8'h72);
        check("sb_start", n_start, s0 + 8'h01);
        check("sb_sen_held", 8'(sen_oe), 8'h00);
        op(1'b0, 1'b1, 1'b1, 8'hE1);
        check("sb_data", last_byte, 8'hE1);
        check("sb_stop", n_stop, p0 + 8'h01);
        check("outs_end", 8'({scl_o, sda_o, sen_o}), 8'h00);
    endtask : t_sbus

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("busy_rst", 8'(busy), 8'h00);
        check("oe_rst", 8'({scl_oe, sda_oe, sen_oe}), 8'h00);
        check("outs_rst", 8'({scl_o, sda_o, sen_o}), 8'h00);
        t_write();
        t_read();
        t_nack();
        t_stretch();
        t_off();
        check("sen_i2c", 8'(sen_bad), 8'h00);
        t_sbus();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule : testbench
